//--- pkg/asfc_params.svh
// Register offsets, field positions, reset values and sizes of the FIFO
`ifndef ASFC_PARAMS_SVH
`define ASFC_PARAMS_SVH
`define ASFC_OFS_CTRL      8'h3A
`define ASFC_OFS_STATUS    8'h3B
`define ASFC_OFS_CMD       8'h3C
`define ASFC_OFS_FIFO_DATA 8'h3D
`define ASFC_OFS_LAST_DATA 8'h3E
`define ASFC_CTRL_RESET    24'h040200
`define ASFC_CTRL_WMASK    24'h0FFFFF
`define ASFC_STATUS_RESET  8'h01
`define ASFC_DEPTH         9'h100
`define ASFC_WM_FULL       9'h100
`define ASFC_MODE_OFF      2'h0
`define ASFC_MODE_WM       2'h1
`define ASFC_CMD_START_BIT 0
`endif

//--- pkg/asfc_pkg.sv
// Types shared by the conversion-result FIFO control logic
package asfc_pkg;
  // One conversion result with its header
  typedef struct packed {
    logic [7:0]  hdr;
    logic [15:0] data;
  } asfc_sample_t;
  // Control register layout, bit 23 down to bit 0
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic       add_status;
    logic       add_header;
    logic [1:0] mode;
    logic       rsvd15;
    logic       wr_err_en;
    logic       rd_err_en;
    logic       upper_limit_irq_enable;
    logic       lower_limit_irq_enable;
    logic       ovr_en;
    logic       wm_en;
    logic       empty_en;
    logic [7:0] watermark;
  } asfc_ctrl_t;
  // Position within a read stream
  typedef enum logic [3:0] {
    PH_IDLE   = 4'h1,
    PH_STATUS = 4'h2,
    PH_HEADER = 4'h4,
    PH_DATA   = 4'h8
  } asfc_phase_t;
  // Whole state of the controller
  typedef struct packed {
    asfc_ctrl_t   ctrl;
    asfc_phase_t  phase;
    logic         stream;
    logic [7:0]   wr_ptr;
    logic [7:0]   rd_ptr;
    logic [8:0]   count;
    logic         hold;
    logic         ovr;
    logic         rd_err;
    logic         wr_err;
    logic         upper_limit_flag;
    logic         lower_limit_flag;
    asfc_sample_t last;
    logic [23:0]  rdata;
    logic         irq;
  } asfc_state_t;
endpackage : asfc_pkg

//--- hdl/asfc_top.sv
// Conversion-result FIFO with mode policy, status flags and interrupt
//
// Overview of operation
// R1 - Mode 00 off, 01 watermark, 1x streaming
// R2 - Watermark mode keeps first N, drops newer
// R3 - Streaming full drops oldest, stores newest
// R4 - Streaming drop of oldest sets overrun flag
// R5 - Host writes zero to reserved bit 15
// R6 - Write-error enable gates write-error flag
// R7 - Read-error enable gates read-error flag
// R8 - Upper-limit enable gates upper-limit flag
// R9 - Lower-limit enable gates lower-limit flag
// R10 - Overrun enable gates overrun flag
// R11 - Watermark enable resets to one, gates
// R12 - Empty interrupt rises with empty flag
// R13 - Watermark flag at count; zero means 256
// R14 - Host should avoid watermark of one
// R15 - Error flags set only while enabled
// R16 - Status at 0x3B, resets to 0x01
// R17 - Header append puts header per sample
// R18 - Status append once per read stream
// R19 - Interrupt is OR of gated flags, forced low in mode 00
// R20 - Enables survive mode changes
//
// Notes for users of this block
// The read data port holds a value for one cycle only,
// then falls back to zero until the next read strobe.
// While a read stream is open, arriving conversions are
// not stored; outside mode 00 they raise the write error instead. This
// keeps a push and a pop from meeting in one cycle, so
// the pointers never need to arbitrate.
// Sticky flags other than the write error clear on a status read, but an event in
// the same cycle as the read wins and stays visible.
// The interrupt is built from the next state, so it
// rises in the very cycle that the flag itself rises.
// Mode changes keep the stored samples and the enables;
// new conversions follow the new policy, and mode 00 also holds the interrupt low and sets no read error.
// Reserved control bits above bit 19 always read zero.
`include "asfc_params.svh"
module asfc_top
  import asfc_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [23:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output      logic [23:0]  reg_rdata,
  // Conversion results and threshold events
  input  wire logic         conv_valid,
  input  wire asfc_sample_t conv_sample,
  input  wire logic         upper_hit,
  input  wire logic         lower_hit,
  // Interrupt pin
  output      logic         irq
);

  asfc_state_t  s_q;             // Registered state
  asfc_state_t  s_d;             // Next state
  asfc_sample_t mem [256];       // Sample storage
  logic         push;            // Store a sample this cycle
  asfc_sample_t rd_word;         // Oldest stored sample

  // The storage has no reset: only words between the
  // read and write pointers are ever returned, so stale
  // contents after reset are never visible to software.
  // Status byte built from a state image
  function automatic logic [7:0] status_of(input asfc_state_t s);
    logic [7:0] v;
    v[7] = s.wr_err | s.rd_err;
    v[6] = s.wr_err;
    v[5] = s.rd_err;
    v[4] = s.upper_limit_flag;
    v[3] = s.lower_limit_flag;
    v[2] = s.ovr;
    v[1] = (s.count >= wm_limit(s.ctrl.watermark)); // [R13]
    v[0] = (s.count == 9'h000);
    return v;
  endfunction : status_of

  // Sample count meant by the watermark field
  // A field of zero means the whole buffer depth
  function automatic logic [8:0] wm_limit(input logic [7:0] wm);
    if (wm == 8'h00) begin
      return `ASFC_WM_FULL; // [R13]
    end
    return {1'b0, wm}; // [R13]
  endfunction : wm_limit

  // First phase of a new read stream
  // Status comes first if asked for, then headers
  function automatic asfc_phase_t first_phase(input asfc_ctrl_t c);
    if (c.add_status) begin
      return PH_STATUS; // [R18]
    end
    if (c.add_header) begin
      return PH_HEADER; // [R17]
    end
    return PH_DATA;
  endfunction : first_phase

  // Word at the read pointer, used by the stream reads
  assign rd_word = mem[s_q.rd_ptr];

  // Next-state logic
  always_comb begin
    logic       fifo_on;
    logic       pop;
    logic [7:0] gated;
    logic [7:0] nst;
    fifo_on = 1'b0;
    pop     = 1'b0;
    gated   = 8'h00;
    nst     = 8'h00;
    s_d     = s_q;
    push    = 1'b0;
    s_d.rdata = 24'h000000;
    fifo_on = (s_q.ctrl.mode != `ASFC_MODE_OFF); // [R1]

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `ASFC_OFS_CTRL: begin
          // Enables are kept as written, whatever the mode
          s_d.ctrl = asfc_ctrl_t'(reg_wdata & `ASFC_CTRL_WMASK); // [R20]
        end
        `ASFC_OFS_CMD: begin
          // Start or stop a read stream
          s_d.stream = reg_wdata[`ASFC_CMD_START_BIT];
          s_d.phase  = reg_wdata[`ASFC_CMD_START_BIT] ?
                       first_phase(s_q.ctrl) : PH_IDLE;
        end
        default: begin
          // Other addresses ignore writes
        end
      endcase
    end

    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        `ASFC_OFS_CTRL: begin
          s_d.rdata = s_q.ctrl;
        end
        `ASFC_OFS_STATUS: begin
          // Read clears sticky flags except the write error; sets below win
          s_d.rdata            = {16'h0000, status_of(s_q)}; // [R16]
          s_d.ovr              = 1'b0;
          s_d.rd_err           = 1'b0;
          s_d.upper_limit_flag = 1'b0;
          s_d.lower_limit_flag = 1'b0;
        end
        `ASFC_OFS_CMD: begin
          s_d.rdata = {23'h000000, s_q.stream};
        end
        `ASFC_OFS_LAST_DATA: begin
          // Data register, used when the FIFO is off
          s_d.rdata = {8'h00, s_q.last.data}; // [R1]
        end
        `ASFC_OFS_FIFO_DATA: begin
          unique case (s_q.phase)
            PH_IDLE: begin
              // No stream open, read returns zero
            end
            PH_STATUS: begin
              // Status goes once at stream start
              s_d.rdata = {16'h0000, status_of(s_q)}; // [R18]
              s_d.phase = s_q.ctrl.add_header ? PH_HEADER : PH_DATA;
            end
            PH_HEADER: begin
              if (s_q.count == 9'h000) begin
                s_d.rd_err = fifo_on; // [R15]
              end else begin
                s_d.rdata = {16'h0000, rd_word.hdr}; // [R17]
                s_d.phase = PH_DATA;
              end
            end
            PH_DATA: begin
              if (s_q.count == 9'h000) begin
                s_d.rd_err = fifo_on; // [R15]
              end else begin
                // Reading removes the sample
                s_d.rdata = {8'h00, rd_word.data}; // [R2]
                pop       = 1'b1;
                s_d.phase = s_q.ctrl.add_header ? PH_HEADER : PH_DATA;
              end
            end
          endcase
        end
        default: begin
          // Unmapped address reads zero
        end
      endcase
    end

    // Pop bookkeeping
    if (pop) begin
      s_d.rd_ptr = s_q.rd_ptr + 8'h01;
      s_d.count  = s_q.count - 9'h001;
      if (s_q.count == 9'h001) begin
        // Emptied: write error and watermark hold end
        s_d.wr_err = 1'b0;
        s_d.hold   = 1'b0; // [R2]
      end
    end

    // Conversion arrival
    if (conv_valid) begin
      s_d.last = conv_sample;
      if (fifo_on) begin
        if (s_q.stream) begin
          // Sample lost to an ongoing read
          s_d.wr_err = 1'b1; // [R15]
        end else if (s_q.ctrl.mode == `ASFC_MODE_WM) begin
          if (s_q.hold) begin
            // Full at watermark: newest is discarded
            s_d.wr_err = 1'b1; // [R2]
            s_d.ovr    = 1'b1; // [R15]
          end else begin
            push       = 1'b1; // [R2]
            s_d.wr_ptr = s_q.wr_ptr + 8'h01;
            s_d.count  = s_q.count + 9'h001;
            if ((s_q.count + 9'h001) >= wm_limit(s_q.ctrl.watermark)) begin
              s_d.hold = 1'b1; // [R2]
            end
          end
        end else begin
          // Streaming keeps the newest samples
          push       = 1'b1;
          s_d.wr_ptr = s_q.wr_ptr + 8'h01;
          if (s_q.count == `ASFC_DEPTH) begin
            s_d.rd_ptr = s_q.rd_ptr + 8'h01; // [R3]
            s_d.ovr    = 1'b1; // [R4]
          end else begin
            s_d.count = s_q.count + 9'h001;
          end
        end
      end
    end

    // Threshold events, sticky until status read
    if (upper_hit) begin
      s_d.upper_limit_flag = 1'b1;
    end
    if (lower_hit) begin
      s_d.lower_limit_flag = 1'b1;
    end

    // Interrupt from next flags, so it rises with them
    nst      = status_of(s_d);
    gated[0] = s_d.ctrl.empty_en & nst[0]; // [R12]
    gated[1] = s_d.ctrl.wm_en & nst[1]; // [R11]
    gated[2] = s_d.ctrl.ovr_en & s_d.ovr; // [R10]
    gated[3] = s_d.ctrl.lower_limit_irq_enable
               & s_d.lower_limit_flag; // [R9]
    gated[4] = s_d.ctrl.upper_limit_irq_enable
               & s_d.upper_limit_flag; // [R8]
    gated[5] = s_d.ctrl.rd_err_en & s_d.rd_err; // [R7]
    gated[6] = s_d.ctrl.wr_err_en & s_d.wr_err; // [R6]
    s_d.irq  = (s_d.ctrl.mode != `ASFC_MODE_OFF) & (|gated); // [R19] [R20]
  end

  // State register with synchronous reset
  // Control comes out of reset with the watermark
  // interrupt enabled and headers appended; the
  // buffer itself starts empty and disabled.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q                  <= '0;
      s_q.ctrl             <= asfc_ctrl_t'(`ASFC_CTRL_RESET); // [R11]
      s_q.phase            <= PH_IDLE;
      s_q.count            <= 9'h000; // [R16]
    end else begin
      s_q <= s_d;
    end
  end

  // Sample storage write port
  // In streaming with a full buffer the write lands on
  // the oldest word, which the read pointer has skipped.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[s_q.wr_ptr] <= conv_sample;
    end
  end

  // Outputs straight from flops
  // Both are fields of the registered state image
  assign reg_rdata = s_q.rdata;
  assign irq       = s_q.irq;

endmodule : asfc_top

//--- verification/asfc_fifo_properties.sv
// Port-level assertions for the FIFO control block
module asfc_fifo_properties
  import asfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [23:0] reg_rdata,
  // Conversions, threshold events, interrupt
  input wire logic conv_valid,
  input wire asfc_sample_t conv_sample,
  input wire logic upper_hit,
  input wire logic lower_hit,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  asfc_ctrl_t c_q; // Shadow of the control register
  wire logic st_rd = reg_rd && reg_addr == 8'h3B; // Status read
  wire logic on = c_q.mode != 2'h0; // Buffer enabled
  // Follow control writes
  always_ff @(posedge ref_clk) begin
    if (!rstn) c_q <= 24'h040200;
    else if (reg_wr && reg_addr == 8'h3A) c_q <= reg_wdata & 24'h0FFFFF;
  end
  property p_ctrl_read;
    $past(reg_rd && reg_addr == 8'h3A) |-> reg_rdata == $past(c_q);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
  property p_status_err;
    $past(st_rd) |-> reg_rdata[23:8] == 16'h0
      && reg_rdata[7] == (reg_rdata[6] | reg_rdata[5]);
  endproperty
  a_status_err: assert property (p_status_err) else $error("status");
  property p_off_quiet;
    !on |-> !irq;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("irq off");
  property p_irq_cause;
    irq |-> c_q[14:8] != 7'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq en");
  property p_rise_cause;
    $rose(irq) |-> $past(conv_valid | upper_hit | lower_hit | reg_wr | reg_rd);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("irq rise");
  property p_empty_irq;
    $past(st_rd && !conv_valid) && reg_rdata[0] && c_q.empty_en && on |-> irq;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty irq");
  property p_wm_irq;
    $past(st_rd) && reg_rdata[1] && c_q.wm_en && on |-> irq;
  endproperty
  a_wm_irq: assert property (p_wm_irq) else $error("wm irq");
  property p_up_irq;
    upper_hit && c_q.upper_limit_irq_enable && on && !reg_wr |=> irq;
  endproperty
  a_up_irq: assert property (p_up_irq) else $error("upper irq");
endmodule : asfc_fifo_properties

//--- verification/asfc_host.sv
// Host model driving the register port
module asfc_host
  import asfc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [23:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [23:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // One write; reserved bit 15 always cleared, watermark passed on as given
  task wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d & 24'hFF7FFF;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One read; data taken in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : asfc_host

//--- verification/tb_adc_sample_fifo_control.sv
// Self-checking bench for the FIFO control block
module tb_adc_sample_fifo_control;
  import asfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rstn = 0, reg_wr, reg_rd, irq;
  logic conv_valid = 0, upper_hit = 0, lower_hit = 0;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, v;
  asfc_sample_t conv_sample = '0, x, q[$]; // Model contents
  logic [31:0] s = 37;
  int bad_count = 0, comparisons = 0, n = 256, md = 0, i, k;
  bit up, lo, ov, re, we, hold;
  always #2 ref_clk = ~ref_clk;
  asfc_top i_asfc_top (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .conv_valid, .conv_sample, .upper_hit,
    .lower_hit, .irq);
  asfc_host i_asfc_host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  function logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Expected status word
  function logic [23:0] stat();
    return {16'h0, we | re, we, re, up, lo, ov, q.size() >= n, q.size() == 0};
  endfunction : stat
  task chk(input string nm, input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One conversion, applied to the model by mode
  task push();
    x = asfc_sample_t'(xs());
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_sample <= x;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    if (md >= 2) begin
      ov |= q.size() == 256;
      if (q.size() == 256) void'(q.pop_front());
      q.push_back(x);
    end else if (md == 1) begin
      if (hold) {we, ov} = 2'b11;
      else q.push_back(x);
      hold |= q.size() == n;
    end
  endtask : push
  task rdst();
    i_asfc_host.rd(8'h3B, v);
    chk("status", v, stat());
    {up, lo, ov, re} = '0;
  endtask : rdst
  // Stream read of a header or a data word
  task rdd(input bit hd);
    i_asfc_host.rd(8'h3D, v);
    x = '0;
    if (hd) x = q[0];
    else if (q.size() != 0) x = q.pop_front();
    else re = md != 0;
    if (q.size() == 0) {we, hold} = 2'b0;
    chk("stream", v, hd ? {16'h0, x.hdr} : {8'h0, x.data});
  endtask : rdd
  task give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rdst();
    i_asfc_host.rd(8'h3A, v);
    chk("control", v, 24'h040200);
    i_asfc_host.rd(8'h30, v);
    chk("unmapped", v, 24'h0);
    // Disabled: data register only
    push();
    i_asfc_host.rd(8'h3E, v);
    chk("last", {8'h0, v[15:0]}, {8'h0, x.data});
    rdst();
    // Streaming, watermark 0 meaning 256
    i_asfc_host.wr(8'h3A, 24'h020500);
    md = 2;
    for (i = 0; i < 257; i++) push();
    @(negedge ref_clk);
    chk("irq", {23'h0, irq}, 24'h1);
    rdst();
    i_asfc_host.wr(8'h3C, 24'h1);
    for (i = 0; i < 257; i++) rdd(0);
    chk("irq", {23'h0, irq}, 24'h1);
    i_asfc_host.wr(8'h3C, 24'h0);
    rdst();
    // Watermark 3 with status and headers appended
    i_asfc_host.wr(8'h3A, 24'h0D2203);
    md = 1;
    n = 3;
    for (i = 0; i < 5; i++) push();
    rdst();
    i_asfc_host.wr(8'h3C, 24'h1);
    i_asfc_host.rd(8'h3D, v);
    chk("lead", v, stat());
    for (i = 0; i < 6; i++) rdd(i % 2 == 0);
    i_asfc_host.wr(8'h3C, 24'h0);
    push();
    rdst();
    n = 256;
    // Threshold events, each with its own enable
    for (k = 0; k < 2; k++) begin
      i_asfc_host.wr(8'h3A, 24'h010000 | (24'h1000 >> k));
      @(posedge ref_clk);
      upper_hit <= k == 0;
      lower_hit <= k == 1;
      @(posedge ref_clk);
      {upper_hit, lower_hit} <= 2'b0;
      {up, lo} = {k == 0, k == 1};
      @(negedge ref_clk);
      chk("irq", {23'h0, irq}, 24'h1);
      rdst();
      chk("irq", {23'h0, irq}, 24'h0);
    end
    give_verdict();
  end
  // Watchdog
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end
endmodule : tb_adc_sample_fifo_control
bind asfc_top asfc_fifo_properties i_asfc_fifo_properties (.ref_clk, .rstn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_valid,
  .conv_sample, .upper_hit, .lower_hit, .irq);
